// ===== core/aru_regs.svh
// constants for the audio router sync and mode control block
`ifndef ARU_REGS_SVH
`define ARU_REGS_SVH

// ---------------------------------------------------------------
// matrix size
// ---------------------------------------------------------------
// stereo ports per direction
`define ARU_PORTS 16
// mono channels per direction, twice the stereo port count
`define ARU_CHANS 32
`define ARU_PORT_W 4
`define ARU_CHAN_W 5
`define ARU_SAMPLE_W 24

// ---------------------------------------------------------------
// buffering
// ---------------------------------------------------------------
`define ARU_FIFO_DEPTH 16
`define ARU_LEVEL_W 5
// level at which one sample is omitted per output tick
`define ARU_FIFO_HIGH 5'h0C

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// 25 MHz system clock
`define ARU_CLK_HZ 64'h0000_0000_017D_7840
// 48 kHz nominal output rate
`define ARU_OUT_RATE_HZ 64'h0000_0000_0000_BB80
// 15 minutes grace before falling back
`define ARU_GRACE_MIN 64'h0000_0000_0000_000F
`define ARU_SEC_PER_MIN 64'h0000_0000_0000_003C
`define ARU_TICK_W 10
`define ARU_GRACE_W 36

`endif

// ===== core/aru_pkg.sv
// types shared by the audio router sync and mode control block
package aru_pkg;

`include "aru_regs.svh"

  // -------------------------------------------------------------
  // operating modes
  // -------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_ASYNC,
    MODE_SYNC,
    MODE_GRACE
  } aru_mode_t;

  // -------------------------------------------------------------
  // stream and control carriers
  // -------------------------------------------------------------
  typedef struct packed
  {
    logic valid;
    logic [`ARU_SAMPLE_W-1:0] left;
    logic [`ARU_SAMPLE_W-1:0] right;
  } aru_stereo_t;

  // for stereo requests only the low port bits of dest and src count
  typedef struct packed
  {
    logic valid;
    logic fromPanel;
    logic mono;
    logic [`ARU_CHAN_W-1:0] dest;
    logic [`ARU_CHAN_W-1:0] src;
  } aru_req_t;

  typedef struct packed
  {
    logic sampleValid;
    logic dropPend;
    logic [`ARU_SAMPLE_W-1:0] last;
  } aru_adapt_t;

  typedef struct packed
  {
    aru_mode_t mode;
    logic [`ARU_GRACE_W-1:0] graceCnt;
    logic [`ARU_TICK_W-1:0] tickCnt;
    logic [1:0] refPresSync;
    logic [2:0] refFrameSync;
    aru_req_t pend;
    logic [`ARU_CHANS-1:0][`ARU_CHAN_W-1:0] xpt;
    logic reqDone;
    logic reqRefused;
    logic syncMode;
    logic graceFlag;
    logic overrun;
    aru_stereo_t [`ARU_PORTS-1:0] out;
  } aru_main_t;

endpackage

// ===== core/aru_fifo.sv
// sample buffer with valid and ready on both sides
`timescale 1ns/1ps

module aru_fifo
  import aru_pkg::*;
#(
  parameter int WIDTH = `ARU_SAMPLE_W,
  parameter int DEPTH = `ARU_FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed
  {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } aru_fifo_st_t;

  aru_fifo_st_t st_ff;
  aru_fifo_st_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWr;
  logic doRd;

  assign inReady = (st_ff.cnt != CW'(DEPTH));
  assign outValid = (st_ff.cnt != '0);
  assign outData = mem[st_ff.rp];
  assign level = st_ff.cnt;
  assign doWr = inValid & inReady & ~flush;
  assign doRd = outValid & outReady & ~flush;

  always_comb
  begin
    nxt_st = st_ff;
    if (flush)
    begin
      nxt_st = '0;
    end
    else
    begin
      if (doWr)
        nxt_st.wp = PW'(st_ff.wp + 1'b1);
      if (doRd)
        nxt_st.rp = PW'(st_ff.rp + 1'b1);
      if (doWr && !doRd)
        nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
      else if (doRd && !doWr)
        nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // storage needs no reset; it is read only while counted
  always_ff @(posedge sys_clk)
  begin
    if (doWr)
      mem[st_ff.wp] <= inData;
  end

endmodule

// ===== core/aru_rate_adapt.sv
// fixed rate output of one mono channel by single adds and drops
`timescale 1ns/1ps

module aru_rate_adapt
  import aru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic fifoValid,
  input wire logic [`ARU_SAMPLE_W-1:0] fifoData,
  input wire logic [`ARU_LEVEL_W-1:0] fifoLevel,
  output logic fifoPop,
  output logic sampleValid,
  output logic [`ARU_SAMPLE_W-1:0] sample
);

  aru_adapt_t st_ff;
  aru_adapt_t nxt_st;

  assign sampleValid = st_ff.sampleValid;
  assign sample = st_ff.last;

  // one pop per tick, plus at most one discarded pop after it
  assign fifoPop = enable & fifoValid & (tick | st_ff.dropPend);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sampleValid = 1'b0;
    nxt_st.dropPend = 1'b0;
    if (!enable)
    begin
      nxt_st.last = '0;
    end
    else if (tick)
    begin
      nxt_st.sampleValid = 1'b1;
      if (fifoValid)
      begin
        nxt_st.last = fifoData;
        // fast source: omit the next single sample
        nxt_st.dropPend = (fifoLevel >= `ARU_FIFO_HIGH);
      end
      // slow source: last stays and is sent again
    end
    // locked source keeps the level between empty and high
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

endmodule

// ===== core/aru_router_ctrl.sv
// mode control, crosspoint and sample path of the audio router
//
// Notes on behaviour
// - with reference, regenerate outputs at 48 kHz
// - asynchronous mode forwards inputs with no processing
// - synchronous mode allows mono routing, 2N signals
// - asynchronous mode: stereo pairs only, refuse mono
// - with reference, switch aligned to reference frames
// - synchronous mode accepts any supported input rate
// - reference-locked input: no adds, no drops
// - slow source: repeat latest sample occasionally
// - fast source: omit incoming samples occasionally
// - adds and drops one sample at a time
// - 16 stereo ports or 32 mono channels
// - mono only from control system, only synchronous
// - asynchronous output equals input, same rate
// - power up asynchronous, then sync if reference
// - reference appearing: enter synchronous mode at once
// - reference lost: wait 15 minutes, then async
`timescale 1ns/1ps

module aru_router_ctrl
  import aru_pkg::*;
#(
  parameter logic [`ARU_GRACE_W-1:0] GRACE_CYCLES =
    `ARU_GRACE_W'(`ARU_GRACE_MIN * `ARU_SEC_PER_MIN * `ARU_CLK_HZ)
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic refPresent,
  input wire logic refFrame,
  input wire aru_req_t ctrlReq,
  output logic reqBusy,
  output logic reqDone,
  output logic reqRefused,
  output logic syncMode,
  output logic graceActive,
  output logic audioOverrun,
  input wire aru_stereo_t [`ARU_PORTS-1:0] audioIn,
  output aru_stereo_t [`ARU_PORTS-1:0] audioOut
);

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [`ARU_TICK_W-1:0] TICK_CYCLES =
    `ARU_TICK_W'(`ARU_CLK_HZ / `ARU_OUT_RATE_HZ);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [`ARU_PORT_W-1:0] pairOf
  (
    input logic [`ARU_CHAN_W-1:0] ch
  );
    return ch[`ARU_CHAN_W-1:1];
  endfunction

  function automatic logic [`ARU_CHAN_W-1:0] chanOf
  (
    input logic [`ARU_PORT_W-1:0] port,
    input logic right
  );
    return {port, right};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aru_main_t st_ff;
  aru_main_t nxt_st;

  logic refPres;
  logic refEdge;
  logic tick;
  logic [`ARU_CHANS-1:0] fifoInValid;
  logic [`ARU_CHANS-1:0] fifoInReady;
  logic [`ARU_CHANS-1:0][`ARU_SAMPLE_W-1:0] fifoInData;
  logic [`ARU_CHANS-1:0] fifoOutValid;
  logic [`ARU_CHANS-1:0] fifoPop;
  logic [`ARU_CHANS-1:0][`ARU_SAMPLE_W-1:0] fifoOutData;
  logic [`ARU_CHANS-1:0][`ARU_LEVEL_W-1:0] fifoLevel;
  logic [`ARU_CHANS-1:0] adValid;
  logic [`ARU_CHANS-1:0][`ARU_SAMPLE_W-1:0] adSample;

  assign refPres = st_ff.refPresSync[1];
  assign refEdge = st_ff.refFrameSync[1] & ~st_ff.refFrameSync[2];
  assign tick = (st_ff.tickCnt == TICK_CYCLES - 1'b1);

  assign reqBusy = st_ff.pend.valid;
  assign reqDone = st_ff.reqDone;
  assign reqRefused = st_ff.reqRefused;
  assign syncMode = st_ff.syncMode;
  assign graceActive = st_ff.graceFlag;
  assign audioOverrun = st_ff.overrun;
  assign audioOut = st_ff.out;

  // ---------------------------------------------------------------
  // per mono channel buffering and rate adaption
  // ---------------------------------------------------------------
  generate
    for (genvar m = 0; m < `ARU_CHANS; m++)
    begin : g_chan
      aru_fifo #(
        .WIDTH(`ARU_SAMPLE_W),
        .DEPTH(`ARU_FIFO_DEPTH)
      ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(~st_ff.syncMode),
        .inValid(fifoInValid[m]),
        .inReady(fifoInReady[m]),
        .inData(fifoInData[m]),
        .outValid(fifoOutValid[m]),
        .outReady(fifoPop[m]),
        .outData(fifoOutData[m]),
        .level(fifoLevel[m])
      );

      aru_rate_adapt u_adapt (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(st_ff.syncMode),
        .tick(tick),
        .fifoValid(fifoOutValid[m]),
        .fifoData(fifoOutData[m]),
        .fifoLevel(fifoLevel[m]),
        .fifoPop(fifoPop[m]),
        .sampleValid(adValid[m]),
        .sample(adSample[m])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // buffer fill from the selected mono sources
  // ---------------------------------------------------------------
  // each mono output takes its own source at that source's rate
  always_comb
  begin
    logic [`ARU_PORT_W-1:0] sp;
    sp = '0;
    fifoInValid = '0;
    fifoInData = '0;
    for (int m = 0; m < `ARU_CHANS; m++)
    begin
      sp = pairOf(st_ff.xpt[m]);
      fifoInValid[m] = st_ff.syncMode & audioIn[sp].valid;
      if (st_ff.xpt[m][0])
        fifoInData[m] = audioIn[sp].right;
      else
        fifoInData[m] = audioIn[sp].left;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [`ARU_PORT_W-1:0] sp;
    logic [`ARU_PORT_W-1:0] dp;
    sp = '0;
    dp = '0;
    nxt_st = st_ff;
    nxt_st.reqDone = 1'b0;
    nxt_st.reqRefused = 1'b0;

    // pin synchronisers
    nxt_st.refPresSync = {st_ff.refPresSync[0], refPresent};
    nxt_st.refFrameSync = {st_ff.refFrameSync[1:0], refFrame};

    // output sample clock, nominal 48 kHz
    if (tick)
      nxt_st.tickCnt = '0;
    else
      nxt_st.tickCnt = `ARU_TICK_W'(st_ff.tickCnt + 1'b1);

    // mode control
    case (st_ff.mode)
      MODE_ASYNC:
      begin
        if (refPres)
          nxt_st.mode = MODE_SYNC;
      end
      MODE_SYNC:
      begin
        if (!refPres)
        begin
          nxt_st.mode = MODE_GRACE;
          nxt_st.graceCnt = '0;
        end
      end
      MODE_GRACE:
      begin
        if (refPres)
          nxt_st.mode = MODE_SYNC;
        else if (st_ff.graceCnt >= GRACE_CYCLES - 1'b1)
          nxt_st.mode = MODE_ASYNC;
        else
          nxt_st.graceCnt = `ARU_GRACE_W'(st_ff.graceCnt + 1'b1);
      end
      default:
      begin
        nxt_st.mode = MODE_ASYNC;
      end
    endcase
    nxt_st.syncMode = (nxt_st.mode != MODE_ASYNC);
    nxt_st.graceFlag = (nxt_st.mode == MODE_GRACE);

    // request intake: mono needs control system and sync mode
    if (ctrlReq.valid && !st_ff.pend.valid)
    begin
      if (ctrlReq.mono && (ctrlReq.fromPanel || !st_ff.syncMode))
        nxt_st.reqRefused = 1'b1;
      else
        nxt_st.pend = ctrlReq;
    end

    // crosspoint change, on a reference frame when one is present
    if (st_ff.pend.valid && (!refPres || refEdge))
    begin
      nxt_st.pend.valid = 1'b0;
      if (st_ff.pend.mono && !st_ff.syncMode)
      begin
        // mode fell back while the change waited
        nxt_st.reqRefused = 1'b1;
      end
      else if (st_ff.pend.mono)
      begin
        nxt_st.xpt[st_ff.pend.dest] = st_ff.pend.src;
        nxt_st.reqDone = 1'b1;
      end
      else
      begin
        dp = st_ff.pend.dest[`ARU_PORT_W-1:0];
        sp = st_ff.pend.src[`ARU_PORT_W-1:0];
        nxt_st.xpt[chanOf(dp, 1'b0)] = chanOf(sp, 1'b0);
        nxt_st.xpt[chanOf(dp, 1'b1)] = chanOf(sp, 1'b1);
        nxt_st.reqDone = 1'b1;
      end
    end

    // output streams
    for (int d = 0; d < `ARU_PORTS; d++)
    begin
      dp = `ARU_PORT_W'(d);
      if (st_ff.syncMode)
      begin
        nxt_st.out[d].valid = adValid[chanOf(dp, 1'b0)];
        nxt_st.out[d].left = adSample[chanOf(dp, 1'b0)];
        nxt_st.out[d].right = adSample[chanOf(dp, 1'b1)];
      end
      else
      begin
        // whole pair of the left channel's source, untouched
        sp = pairOf(st_ff.xpt[chanOf(dp, 1'b0)]);
        nxt_st.out[d] = audioIn[sp];
      end
    end

    // sticky sign that a buffer refused a sample
    for (int m = 0; m < `ARU_CHANS; m++)
    begin
      if (fifoInValid[m] && !fifoInReady[m])
        nxt_st.overrun = 1'b1;
    end
    if (!st_ff.syncMode)
      nxt_st.overrun = 1'b0;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.mode <= MODE_ASYNC;
      for (int m = 0; m < `ARU_CHANS; m++)
        st_ff.xpt[m] <= `ARU_CHAN_W'(m);
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ===== sim/aru_props.sv
// assertions on the router mode control ports
`timescale 1ns/1ps

module aru_props
  import aru_pkg::*;
#(
  parameter logic [`ARU_GRACE_W-1:0] GRACE_CYCLES = 50
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic refPresent,
  input wire logic refFrame,
  input wire aru_req_t ctrlReq,
  input wire logic reqBusy,
  input wire logic reqDone,
  input wire logic reqRefused,
  input wire logic syncMode,
  input wire logic graceActive,
  input wire logic audioOverrun,
  input wire aru_stereo_t [`ARU_PORTS-1:0] audioIn,
  input wire aru_stereo_t [`ARU_PORTS-1:0] audioOut
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [`ARU_GRACE_W-1:0] lostCnt;
  logic [11:0] gap;
  logic [3:0] frameAge;
  logic frameQ;
  logic syncSeen;
  logic syncQ;
  always_ff @(posedge sys_clk)
  begin
    frameQ <= refFrame;
    syncQ <= syncMode;
    lostCnt <= (rst || refPresent) ? '0 : lostCnt + 1'b1;
    gap <= audioOut[0].valid ? 12'h000 : gap + {11'h000, gap != 12'hFFF};
    // first cycle of sync still shows pass-through output
    syncSeen <= !rst && syncMode && (syncSeen || (audioOut[0].valid && syncQ));
    if (refFrame && !frameQ)
      frameAge <= 4'h0;
    else if (frameAge != 4'hF)
      frameAge <= frameAge + 4'h1;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_take;
    ctrlReq.valid && !reqBusy;
  endsequence
  sequence s_apply;
    reqBusy ##1 reqDone;
  endsequence
  property p_refuse_panel;
    s_take ##0 (ctrlReq.mono && ctrlReq.fromPanel) |=> reqRefused && !reqDone;
  endproperty
  property p_refuse_async;
    s_take ##0 (ctrlReq.mono && !syncMode) |=> reqRefused;
  endproperty
  property p_apply_now;
    s_take ##0 (!ctrlReq.mono && !syncMode && !refPresent
      && $past(refPresent, 3) == 1'b0) |=> s_apply;
  endproperty
  property p_enter_sync;
    refPresent [*6] |-> syncMode;
  endproperty
  property p_grace_sync;
    graceActive |-> syncMode;
  endproperty
  property p_grace_return;
    refPresent [*6] |-> !graceActive;
  endproperty
  property p_grace_len;
    $fell(syncMode) && !$past(rst) |->
      lostCnt >= GRACE_CYCLES && lostCnt <= GRACE_CYCLES + 8;
  endproperty
  property p_frame_align;
    reqDone && refPresent && $past(refPresent, 6) |->
      frameAge inside {[1:5]};
  endproperty
  property p_out_rate;
    audioOut[0].valid && syncSeen && syncMode |-> gap == 12'h207;
  endproperty
  property p_power_up;
    $fell(rst) |-> !syncMode ##1 !syncMode;
  endproperty

  a_refuse_panel: assert property (p_refuse_panel)
    else $error("mono panel request not refused");
  a_refuse_async: assert property (p_refuse_async)
    else $error("mono request accepted while async");
  a_apply_now: assert property (p_apply_now)
    else $error("stereo change not applied at once");
  a_enter_sync: assert property (p_enter_sync)
    else $error("sync mode not entered");
  a_grace_sync: assert property (p_grace_sync)
    else $error("grace without sync mode");
  a_grace_return: assert property (p_grace_return)
    else $error("grace kept with reference back");
  a_grace_len: assert property (p_grace_len)
    else $error("fallback at wrong time");
  a_frame_align: assert property (p_frame_align)
    else $error("change not aligned to frame");
  a_out_rate: assert property (p_out_rate)
    else $error("output tick spacing wrong");
  a_power_up: assert property (p_power_up)
    else $error("not async after reset");
endmodule

bind aru_router_ctrl aru_props #(.GRACE_CYCLES(GRACE_CYCLES)) aru_props_inst
(
  .sys_clk(sys_clk),
  .rst(rst),
  .refPresent(refPresent),
  .refFrame(refFrame),
  .ctrlReq(ctrlReq),
  .reqBusy(reqBusy),
  .reqDone(reqDone),
  .reqRefused(reqRefused),
  .syncMode(syncMode),
  .graceActive(graceActive),
  .audioOverrun(audioOverrun),
  .audioIn(audioIn),
  .audioOut(audioOut)
);

// ===== sim/aru_far_side.sv
// far side model: audio sources and video reference
`timescale 1ns/1ps

module aru_far_side
  import aru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic refOn,
  input wire logic [11:0] period,
  output logic refPresent,
  output logic refFrame,
  output aru_stereo_t [`ARU_PORTS-1:0] audioIn
);
  logic [11:0] div = 12'h000;
  logic [7:0] frm = 8'h00;
  logic [23:0] cnt = 24'h00_0000;
  initial
  begin
    refPresent = 1'b0;
    refFrame = 1'b0;
    audioIn = '0;
  end
  always @(posedge sys_clk)
  begin
    refPresent <= refOn;
    frm <= (frm == 8'hC7) ? 8'h00 : frm + 8'h01;
    refFrame <= refOn && frm < 8'h04;
    // source rate set freely by period
    div <= (div + 12'h001 >= period) ? 12'h000 : div + 12'h001;
    if (div == 12'h000)
      cnt <= cnt + 24'h00_0001;
    for (int p = 0; p < `ARU_PORTS; p++)
    begin
      audioIn[p].valid <= div == 12'h000;
      // data idles on a toggling pattern between strobes
      audioIn[p].left <= (div == 12'h000) ? {p[3:0], cnt[19:0]}
        : ~audioIn[p].left;
      audioIn[p].right <= ~audioIn[p].left;
    end
  end
endmodule

// ===== sim/aru_router_ctrl_tb.sv
// self-checking bench for the router mode control
`timescale 1ns/1ps

module aru_router_ctrl_tb
  import aru_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic refOn = 1'b0;
  logic [11:0] period = 12'h014;
  aru_req_t ctrlReq = '0;
  logic refPresent, refFrame, reqBusy, reqDone, reqRefused;
  logic syncMode, graceActive, audioOverrun;
  aru_stereo_t [`ARU_PORTS-1:0] audioIn, audioOut;
  int n_mismatch = 0;
  int total_checks = 0;
  logic rf;

  always #20 sys_clk = ~sys_clk;

  aru_far_side aru_far_side_inst (.sys_clk(sys_clk), .refOn(refOn),
    .period(period), .refPresent(refPresent), .refFrame(refFrame),
    .audioIn(audioIn));
  aru_router_ctrl #(.GRACE_CYCLES(36'h0_0000_0032)) aru_router_ctrl_inst
  (.sys_clk(sys_clk), .rst(rst), .refPresent(refPresent),
    .refFrame(refFrame), .ctrlReq(ctrlReq), .reqBusy(reqBusy),
    .reqDone(reqDone), .reqRefused(reqRefused), .syncMode(syncMode),
    .graceActive(graceActive), .audioOverrun(audioOverrun),
    .audioIn(audioIn), .audioOut(audioOut));

  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic req(input logic m, input logic pn, input logic [4:0] d,
    input logic [4:0] s);
    @(posedge sys_clk);
    ctrlReq <= '{1'b1, pn, m, d, s};
    @(posedge sys_clk);
    ctrlReq.valid <= 1'b0;
    // look after the taking edge has settled, so a refuse pulse is seen
    #1;
    for (int i = 0; i < 600 && !(reqDone || reqRefused); i++)
      cyc(1);
    // no answer at all leaves an unknown that no compare lets pass
    rf = reqDone ? 1'b0 : (reqRefused ? 1'b1 : 1'bx);
  endtask

  task automatic t_async();
    aru_stereo_t v;
    req(1'b0, 1'b0, 5'h03, 5'h05);
    chk(rf, 1'b0);
    for (int i = 0; i < 100 && audioIn[5].valid !== 1'b1; i++)
      cyc(1);
    v = audioIn[5];
    cyc(1);
    chk(audioOut[3], v);
    req(1'b1, 1'b0, 5'h06, 5'h0B);
    chk(rf, 1'b1);
  endtask

  task automatic t_sync();
    @(posedge sys_clk);
    refOn <= 1'b1;
    cyc(6);
    chk(syncMode, 1'b1);
    req(1'b1, 1'b1, 5'h1F, 5'h00);
    chk(rf, 1'b1);
    req(1'b1, 1'b0, 5'h1F, 5'h00);
    chk(rf, 1'b0);
  endtask

  task automatic t_rate();
    int g;
    for (int i = 0; i < 1200 && audioOut[0].valid !== 1'b1; i++)
      cyc(1);
    g = 0;
    do
    begin
      cyc(1);
      g++;
    end
    while (audioOut[0].valid !== 1'b1 && g < 1200);
    chk(g, 520);
  endtask

  task automatic t_buffer();
    logic [23:0] pv;
    int rep;
    cyc(1600);
    chk(audioOverrun, 1'b1);
    @(posedge sys_clk);
    period <= 12'h7D0;
    cyc(14000);
    rep = 0;
    pv = audioOut[0].left;
    for (int k = 0; k < 8; k++)
    begin
      t_rate();
      if (audioOut[0].left === pv)
        rep++;
      else
        chk(audioOut[0].left - pv, 24'h00_0001);
      pv = audioOut[0].left;
    end
    chk(rep > 0, 1'b1);
  endtask

  task automatic t_grace();
    @(posedge sys_clk);
    refOn <= 1'b0;
    cyc(30);
    chk({graceActive, syncMode}, 2'b11);
    @(posedge sys_clk);
    refOn <= 1'b1;
    cyc(10);
    chk({graceActive, syncMode}, 2'b01);
    @(posedge sys_clk);
    refOn <= 1'b0;
    cyc(70);
    chk(syncMode, 1'b0);
  endtask

  task automatic t_reset();
    @(posedge sys_clk);
    refOn <= 1'b1;
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    chk(syncMode, 1'b0);
    cyc(6);
    chk(syncMode, 1'b1);
  endtask

  initial
  begin
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    t_async();
    t_sync();
    t_rate();
    t_buffer();
    t_grace();
    t_reset();
    results();
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule
